// [src/psc_pkg.sv]
// package: register map, field positions and carrier types of the port select slice
package psc_pkg;
    localparam logic [7:0] PSC_OFF_BC_ERR_COUNT = 8'h1b;
    localparam logic [7:0] PSC_OFF_PIN_STATUS = 8'h1c;
    localparam logic [7:0] PSC_OFF_OUTPUT_PORT_SELECT = 8'h1e;
    localparam logic [7:0] PSC_OFF_PIXEL_CLOCK_MEASURE = 8'h1f;
    localparam int PSC_BIT_NEAR_PORT_SELECT = 0;
    localparam int PSC_BIT_FAR_PORT_SELECT = 1;
    localparam int PSC_BIT_SECOND_ADDRESS_ENABLE = 2;
    localparam logic [7:0] PSC_RST_OUTPUT_PORT_SELECT = 8'h01;
    localparam logic [7:0] PSC_RST_PIXEL_CLOCK_MEASURE = 8'h00;
    localparam logic [7:0] PSC_COUNT_MAX = 8'hff;
    localparam logic [6:0] PSC_SECOND_ADDR_STEP = 7'h01;
    // register access request from the serial bus front end
    typedef struct packed {
        logic write;
        logic read;
        logic secondary;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psc_req_t;
    // where a primary or secondary access lands
    typedef struct packed {
        logic writeNear;
        logic writeFar;
        logic writeShared;
        logic readFar;
    } psc_route_t;
    typedef enum logic [0:0] {
        PSC_IDLE = 1'b0,
        PSC_RUN = 1'b1
    } psc_meas_t;
endpackage

// [src/psc_edge_sync.sv]
// three-stage synchroniser with agreement filter and rising edge pulse
`timescale 1ns/10ps
`default_nettype none
module psc_edge_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // asynchronous level in, edge pulse out
    input wire logic async,
    output logic rise
);
    logic s1_q, s2_q, s3_q, stable_q;
    // s1 feeds only s2, to keep metastability out of the filter
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // a change counts only once stages two and three agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            stable_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            stable_q <= s3_q;
        end
    end
    assign rise = s2_q & s3_q & ~stable_q;
endmodule // psc_edge_sync
`default_nettype wire

// [src/psc_port_select.sv]
// port select register, address routing and pixel clock measurement
//
// a primary access reaches the port set picked by the select register, or near and shared
// while the secondary address is enabled; a secondary access, once enabled, always reaches the far port and the shared set;
// the measure register counts pixel clock edges over a run of oscillator periods
// the reset value selects the near port, so primary accesses work out of reset
// the secondary compare wraps from the top address to zero within seven bits
// limitation: the first oscillator period of an interval is partial, so a count
// may fall short by up to one period's worth of edges
// both measurement clocks must stay high and low for two mclk cycles at least,
// or the three-stage synchronisers will miss edges
`timescale 1ns/10ps
`default_nettype none
module psc_port_select
    import psc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus address compare from the serial front end
    input wire logic [6:0] ownBusAddress,
    input wire logic [6:0] rxAddr,
    output logic primaryHit,
    output logic secondaryHit,
    // register access
    input wire psc_req_t req,
    output logic [7:0] rdata_q,
    output logic rdValid_q,
    // routing to the rest of the bank
    output psc_route_t route,
    output logic secondAddressEnable,
    // per-port status sources
    input wire logic [7:0] nearBcErrCount,
    input wire logic [7:0] farBcErrCount,
    input wire logic [7:0] nearPinStatus,
    input wire logic [7:0] farPinStatus,
    // measurement clocks, both asynchronous to mclk
    input wire logic pixelClk,
    input wire logic oscClk,
    output logic measureBusy
);
    // register state
    logic [7:0] portSel_q; // bits 7:3 are reserved and stay zero
    logic [7:0] count_q; // edges seen in the current or the last interval
    logic [7:0] remain_q; // oscillator periods still to run
    psc_meas_t state_q;
    // synchronised rising edge pulses, one mclk wide
    logic pixRise;
    logic oscRise;
    // decoded select bits and the read side choice
    logic farSel;
    logic nearSel;
    logic selFar;
    // qualified strobes
    logic accessOpen;
    logic writeSel;
    logic writeMeasure;
    logic intervalEnd;
    logic countStep;
    // read mux output
    logic [7:0] readVal;

    // pixel clock edges, taken through three flip-flops into the mclk domain
    psc_edge_sync u_pix_sync (
        .mclk(mclk),
        .rst(rst),
        .async(pixelClk),
        .rise(pixRise)
    );
    // oscillator edges pace the interval; same filter, so both see equal latency
    psc_edge_sync u_osc_sync (
        .mclk(mclk),
        .rst(rst),
        .async(oscClk),
        .rise(oscRise)
    );

    // field decode of the select register
    assign secondAddressEnable = portSel_q[PSC_BIT_SECOND_ADDRESS_ENABLE];
    assign farSel = portSel_q[PSC_BIT_FAR_PORT_SELECT];
    assign nearSel = portSel_q[PSC_BIT_NEAR_PORT_SELECT];

    // address compare; the secondary address wraps within seven bits
    // the primary compare is unconditional; what a hit means is decided upstream
    assign primaryHit = (rxAddr == ownBusAddress);
    assign secondaryHit = secondAddressEnable
        && (rxAddr == 7'(ownBusAddress + PSC_SECOND_ADDR_STEP));

    // routing: secondary always lands on far, primary follows the selects unless overridden
    always_comb begin
        // nothing is written unless a branch below routes it
        route = '0;
        if (req.secondary) begin
            // secondary address: far port and shared set, selects play no part
            route.writeFar = req.write;
            route.writeShared = req.write;
            route.readFar = 1'b1;
        end else if (secondAddressEnable) begin
            // selects ignored while the secondary address is enabled: near and shared
            route.writeNear = req.write;
            route.writeShared = req.write;
            route.readFar = 1'b0;
        end else begin
            // primary address: follow the selects, far wins a read when both are set
            route.writeFar = req.write & farSel;
            route.writeNear = req.write & nearSel;
            route.writeShared = req.write & (farSel | nearSel);
            route.readFar = farSel;
        end
    end
    // status reads use the same far choice as the routed read
    assign selFar = route.readFar;

    // a primary write with no select bit set reaches no register set, not even shared
    assign accessOpen = req.secondary || secondAddressEnable || farSel || nearSel;
    // the select and measure registers are shared, so any routed write reaches them
    assign writeSel = req.write && accessOpen && req.addr == PSC_OFF_OUTPUT_PORT_SELECT;
    assign writeMeasure = req.write && accessOpen
        && req.addr == PSC_OFF_PIXEL_CLOCK_MEASURE;

    // port select register, reserved bits stay zero
    // a new enable bit takes effect from the next access, never the current one
    always_ff @(posedge mclk) begin
        if (rst) begin
            portSel_q <= PSC_RST_OUTPUT_PORT_SELECT;
        end else if (writeSel) begin
            portSel_q <= {5'h00, req.wdata[2:0]};
        end
    end

    // the interval ends on the oscillator edge that uses up its last period
    assign intervalEnd = (state_q == PSC_RUN) && oscRise && (remain_q == 8'h01);

    // measurement state: a write arms the interval, a zero interval ends at once
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= PSC_IDLE;
        end else if (writeMeasure) begin
            state_q <= (req.wdata == 8'h00) ? PSC_IDLE : PSC_RUN;
        end else begin
            unique case (state_q)
                PSC_IDLE: begin
                    state_q <= PSC_IDLE;
                end
                PSC_RUN: begin
                    if (intervalEnd) begin
                        state_q <= PSC_IDLE;
                    end
                end
            endcase
        end
    end
    assign measureBusy = (state_q == PSC_RUN);

    // periods left to run; a write during a run restarts from the new value
    always_ff @(posedge mclk) begin
        if (rst) begin
            remain_q <= PSC_RST_PIXEL_CLOCK_MEASURE;
        end else if (writeMeasure) begin
            remain_q <= req.wdata;
        end else if (state_q == PSC_RUN && oscRise) begin
            remain_q <= remain_q - 8'h01;
        end
    end

    // an edge counts only inside a running interval and below the ceiling
    assign countStep = (state_q == PSC_RUN) && pixRise && (count_q != PSC_COUNT_MAX);

    // edge counter; a write restarts from zero, saturation avoids a wrapped low reading
    // the count is cleared by a write, never by a read, so it can be read again
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= PSC_RST_PIXEL_CLOCK_MEASURE;
        end else if (writeMeasure) begin
            count_q <= 8'h00;
        end else if (countStep) begin
            count_q <= count_q + 8'h01;
        end
    end

    // read mux; unmapped offsets read zero so a stray read cannot leak state
    always_comb begin
        unique case (req.addr)
            PSC_OFF_OUTPUT_PORT_SELECT: readVal = portSel_q;
            PSC_OFF_PIXEL_CLOCK_MEASURE: readVal = count_q;
            // per-port status follows the far choice of the routed read
            PSC_OFF_BC_ERR_COUNT: readVal = selFar ? farBcErrCount : nearBcErrCount;
            PSC_OFF_PIN_STATUS: readVal = selFar ? farPinStatus : nearPinStatus;
            default: readVal = 8'h00;
        endcase
    end

    // registered read answer, one cycle after the request
    // rdata_q holds until the next read, so a slow host may still sample it late
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= req.read;
            if (req.read) begin
                rdata_q <= readVal;
            end
        end
    end
endmodule // psc_port_select
`default_nettype wire

// [testbench/psc_chk.sv]
// checker: timing and routing assertions on the port select ports
`timescale 1ns/10ps
`default_nettype none
module psc_chk
    import psc_pkg::*;
(
    // clock, reset and address compare
    input wire logic mclk,
    input wire logic rst,
    input wire logic [6:0] ownBusAddress,
    input wire logic [6:0] rxAddr,
    input wire logic primaryHit,
    input wire logic secondaryHit,
    // register side
    input wire psc_req_t req,
    input wire logic rdValid_q,
    input wire psc_route_t route,
    input wire logic secondAddressEnable,
    input wire logic measureBusy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // a routed write to the measure register
    sequence s_meas;
        req.write && req.addr == 8'h1f && route != 4'h0;
    endsequence
    a_pri_hit: assert property (primaryHit == (rxAddr == ownBusAddress))
        else $error("primary hit wrong");
    a_sec_hit: assert property (secondaryHit ==
        (secondAddressEnable && rxAddr == ownBusAddress + 7'h01)) else $error("second hit wrong");
    a_rd_pulse: assert property (req.read |=> rdValid_q) else $error("no read answer");
    a_sec_route: assert property (req.write && req.secondary |-> route == 4'h7)
        else $error("secondary route wrong");
    a_en_ignore: assert property (req.write && !req.secondary && secondAddressEnable
        |-> route == 4'ha) else $error("selects not ignored");
    a_meas_go: assert property (s_meas ##0 req.wdata != 8'h00 |=> measureBusy)
        else $error("measure not started");
    a_meas_zero: assert property (s_meas ##0 req.wdata == 8'h00 |=> !measureBusy)
        else $error("zero interval ran");
    a_meas_one: assert property (s_meas ##0 req.wdata == 8'h01 |=> ##[1:40] !measureBusy)
        else $error("one period overran");
endmodule // psc_chk
bind psc_port_select psc_chk chk (.mclk(mclk), .rst(rst), .ownBusAddress(ownBusAddress),
    .rxAddr(rxAddr), .primaryHit(primaryHit), .secondaryHit(secondaryHit), .req(req),
    .rdValid_q(rdValid_q), .route(route), .secondAddressEnable(secondAddressEnable),
    .measureBusy(measureBusy));
`default_nettype wire

// [testbench/psc_host_model.sv]
// host model: single register accesses as one-cycle request pulses
`timescale 1ns/10ps
`default_nettype none
module psc_host_model
    import psc_pkg::*;
(
    // clock
    input wire logic mclk,
    // request toward the bank
    output var psc_req_t req
);
    initial req = '0;
    // raise after an edge, drop after the taking edge so no two requests merge
    task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{write: w, read: !w, secondary: s, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
    endtask
endmodule // psc_host_model
`default_nettype wire

// [testbench/test_psc_port_select.sv]
// testbench: port routing, status mux and pixel clock measurement
`timescale 1ns/10ps
`default_nettype none
module test_psc_port_select import psc_pkg::*; ();
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic pixelClk = 1'b0;
    logic oscClk = 1'b0;
    logic [6:0] own = 7'h00;
    logic [6:0] rx = 7'h00;
    logic [4:0] div = 5'h00;
    logic [7:0] rdata_q;
    logic rdValid_q, primaryHit, secondaryHit, secondAddressEnable, measureBusy;
    psc_req_t req;
    psc_route_t route;
    int error_cnt = 0;
    int tests_run = 0;
    // select written, via secondary, select read back, far status expected, own address
    logic [24:0] rows [5] = '{{8'h01, 1'b0, 8'h01, 1'b0, 7'h2c}, {8'h02, 1'b0, 8'h02, 1'b1, 7'h3a},
        {8'hfb, 1'b0, 8'h03, 1'b1, 7'h10}, {8'h07, 1'b0, 8'h07, 1'b0, 7'h7f},
        {8'h07, 1'b1, 8'h07, 1'b1, 7'h55}};
    psc_host_model host (.mclk(mclk), .req(req));
    psc_port_select dut (.mclk(mclk), .rst(rst), .ownBusAddress(own), .rxAddr(rx),
        .primaryHit(primaryHit), .secondaryHit(secondaryHit), .req(req), .rdata_q(rdata_q),
        .rdValid_q(rdValid_q), .route(route), .secondAddressEnable(secondAddressEnable),
        .nearBcErrCount(8'h11), .farBcErrCount(8'h22), .nearPinStatus(8'h33),
        .farPinStatus(8'h44), .pixelClk(pixelClk), .oscClk(oscClk), .measureBusy(measureBusy));
    always #5 mclk = ~mclk;
    // 8 pixel edges per oscillator period, both slow enough for the synchronisers
    always @(posedge mclk) begin
        div <= div + 5'h01;
        pixelClk <= div[1];
        oscClk <= div[4];
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] exp);
        host.acc(1'b0, s, a, 8'h00);
        #1 check(rdata_q, exp);
        check({7'h00, rdValid_q}, 8'h01);
    endtask
    // interval edges are uncertain by one partial period, so a range is checked
    task automatic meas(input logic [7:0] n, input logic [7:0] lo, input logic [7:0] hi);
        int k;
        host.acc(1'b1, 1'b0, 8'h1f, n);
        #1;
        for (k = 0; k < 9000 && measureBusy === 1'b1; k++) #10;
        if (k == 9000) begin
            error_cnt++;
            final_report();
        end
        host.acc(1'b0, 1'b0, 8'h1f, 8'h00);
        #1 check({7'h00, rdata_q >= lo && rdata_q <= hi}, 8'h01);
        $display("measure %h done", n);
    endtask
    initial begin
        logic [7:0] ws, rs;
        logic sc, fr;
        logic [6:0] ow;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(1'b0, 8'h1e, 8'h01);
        rd(1'b0, 8'h1f, 8'h00);
        rd(1'b0, 8'h40, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 5; i++) begin
            {ws, sc, rs, fr, ow} = rows[i];
            @(posedge mclk);
            own <= ow;
            rx <= ow + 7'h01;
            host.acc(1'b1, sc, 8'h1e, ws);
            rd(sc, 8'h1e, rs);
            rd(sc, 8'h1b, fr ? 8'h22 : 8'h11);
            rd(sc, 8'h1c, fr ? 8'h44 : 8'h33);
            check({7'h00, secondaryHit}, {7'h00, ws[2]});
            check({7'h00, primaryHit}, 8'h00);
            $display("row %0d done", i);
        end
        meas(8'hff, 8'hff, 8'hff);
        meas(8'h03, 8'h0e, 8'h1a);
        meas(8'h01, 8'h00, 8'h09);
        host.acc(1'b1, 1'b0, 8'h1f, 8'h00);
        rd(1'b0, 8'h1f, 8'h00);
        // mid-run reset: start a long interval, cut it by reset, expect power-on values
        host.acc(1'b1, 1'b0, 8'h1f, 8'hff);
        #1 check({7'h00, measureBusy}, 8'h01);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rx <= own;
        rd(1'b0, 8'h1e, 8'h01);
        rd(1'b0, 8'h1f, 8'h00);
        check({7'h00, measureBusy}, 8'h00);
        check({7'h00, primaryHit}, 8'h01);
        check({7'h00, secondaryHit}, 8'h00);
        $display("mid-run reset done");
        final_report();
    end
endmodule // test_psc_port_select
`default_nettype wire
